// ==== tid_pkg.sv ====
// How it works
// - Start gate is 2048 times edge-to-tick interval
// - Busy holds until result moved to buffer or an overrun discards it
// - Busy channel ignores further input pulses
// - Gate input qualifies pulses, coincidence or anti
// - Stop disarmed until delay after start elapses
// - Nine stop-arming delay ranges selectable
// - Position zero arms stop regardless of start
// - Stop gate is 2048 times stop interval
// - Stop gate leading edge halts main scaler
// - Result is a 35-bit straight binary word
// - Completion copies result to buffer, then clears
// - Host reads and resets buffer over bus
// - Scaler ready holds while result is held
// - Overrun pulses when interval exceeds chosen range
// - Buffer ready, service request, addressed pulse
// - Independent manual clears for both registers
// - Display valid from digitization until scaler clear
// - Clock source select, selected clock driven out
// - Idle stop inhibit makes paired pulses measure
// - Start plus complement stop, carries into main
// - Stop armed when main reaches preset count
package tid_pkg;
  localparam int SYS_HZ = 250000000;
  localparam int MASTER_HZ = 50000000;
  localparam int DIV_N = SYS_HZ / MASTER_HZ;
  localparam logic [2:0] DIV_LAST = 3'(DIV_N - 1);
  localparam logic [2:0] DIV_HALF = 3'(DIV_N / 2);
  localparam int STRETCH_SH = 11;
  localparam int RES_W = 35;
  localparam int MAIN_W = RES_W - STRETCH_SH;
  localparam int FINE_W = 12;
  // Bus register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_BUFLO = 8'h08;
  localparam logic [7:0] OFS_BUFHI = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_SCLO = 8'h14;
  localparam logic [7:0] OFS_SCHI = 8'h18;
  // Control field positions
  localparam int CB_EXT = 0;
  localparam int CB_ST_ANTI = 1;
  localparam int CB_SP_ANTI = 2;
  localparam int CB_ARM = 4;
  localparam int CB_RANGE = 8;
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [3:0] SEL_MAX = 4'h9;
  localparam int ARM_STEP = 2;
  localparam int RANGE_BASE = 6;
  typedef enum logic [1:0] {
    TID_CH_IDLE = 2'b00, TID_CH_FINE = 2'b01, TID_CH_GATE = 2'b10, TID_CH_DONE = 2'b11
  } tid_ph_t;
  typedef enum logic [1:0] {
    TID_S_IDLE = 2'b00, TID_S_RUN = 2'b01, TID_S_XFER = 2'b10
  } tid_st_t;
  typedef struct packed {
    tid_ph_t ph;
    logic [13:0] cnt;
    logic [FINE_W-1:0] scal;
  } tid_ch_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } tid_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } tid_wb_rsp_t;
  typedef struct packed {
    logic start;
    logic stop;
    logic start_gate;
    logic stop_gate;
    logic ext_clk;
    logic man_clr_sc;
    logic man_clr_buf;
  } tid_pins_t;
endpackage : tid_pkg

// ==== tid_top.sv ====
`timescale 1ns/1ps
module tid_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire tid_pkg::tid_wb_req_t wb_i,
  output tid_pkg::tid_wb_rsp_t wb_o,
  // Front panel pins
  input wire tid_pkg::tid_pins_t pins_i,
  // Status and outputs
  output logic start_busy_o,
  output logic stop_busy_o,
  output logic scaler_rdy_o,
  output logic buf_rdy_o,
  output logic lam_o,
  output logic addressed_o,
  output logic overrun_o,
  output logic clk_out_o,
  output logic disp_valid_o,
  output logic [tid_pkg::RES_W-1:0] disp_o,
  output logic [tid_pkg::RES_W-1:0] buf_o
);
  import tid_pkg::*;

  typedef struct packed {
    tid_pins_t s1;
    tid_pins_t s2;
    tid_pins_t s3;
    logic [2:0] div;
    logic clk_out;
    tid_st_t st;
    tid_ch_t [1:0] ch;
    logic main_open;
    logic [MAIN_W:0] main_cnt;
    logic [11:0] ctrl;
    logic [RES_W-1:0] scaler;
    logic scaler_rdy;
    logic [RES_W-1:0] bufr;
    logic buf_rdy;
    logic addressed;
    logic overrun;
    logic ack;
    logic [31:0] rdat;
  } tid_state_t;

  tid_state_t q, d;
  logic tick;
  logic ext_rise;
  logic [1:0] acc;
  logic [1:0] edge_in;
  logic [1:0] gate_ok;
  logic armed;
  logic [3:0] arm_sel;
  logic [3:0] rng_sel;
  logic [MAIN_W:0] arm_lim;
  logic [MAIN_W:0] rng_lim;
  logic [RES_W-1:0] result;
  logic bus_go;
  logic wr_go;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic clr_buf;
  logic clr_sc;
  logic done_xfer;
  logic ovr_hit;

  // Clock source and stretcher timing base
  assign ext_rise = q.s2.ext_clk & ~q.s3.ext_clk;
  assign tick = q.ctrl[CB_EXT] ? ext_rise : (q.div == DIV_LAST);

  // Selector clipping and derived limits
  assign arm_sel = (q.ctrl[CB_ARM+:4] > SEL_MAX) ? SEL_MAX : q.ctrl[CB_ARM+:4];
  assign rng_sel = (q.ctrl[CB_RANGE+:4] > SEL_MAX) ? SEL_MAX : q.ctrl[CB_RANGE+:4];
  assign arm_lim = (MAIN_W+1)'(1) << (ARM_STEP * (int'(arm_sel) - 1));
  assign rng_lim = (MAIN_W+1)'(1) << (RANGE_BASE + ARM_STEP * int'(rng_sel));

  // Stop arming: zero arms freely, else after preset main count
  always_comb begin
    if (arm_sel == 4'h0) begin
      armed = 1'b1;
    end else begin
      armed = (q.st == TID_S_RUN) && (q.main_cnt >= arm_lim);
    end
  end

  // Input qualification and acceptance
  assign edge_in = {q.s2.stop & ~q.s3.stop, q.s2.start & ~q.s3.start};
  assign gate_ok[0] = q.s2.start_gate ^ q.ctrl[CB_ST_ANTI];
  assign gate_ok[1] = q.s2.stop_gate ^ q.ctrl[CB_SP_ANTI];
  assign acc[0] = edge_in[0] & gate_ok[0] & (q.ch[0].ph == TID_CH_IDLE)
                & (q.st == TID_S_IDLE);
  assign acc[1] = edge_in[1] & gate_ok[1] & (q.ch[1].ph == TID_CH_IDLE) & armed;

  // Start plus two's complement of stop, carries fold into main count
  assign result = {q.main_cnt[MAIN_W-1:0], {STRETCH_SH{1'b0}}}
                + {{(RES_W-FINE_W){1'b0}}, q.ch[0].scal}
                + {{(RES_W-FINE_W){1'b1}}, ~q.ch[1].scal} + RES_W'(1);

  // Bus decode
  assign bus_go = wb_i.cyc & wb_i.stb & ~q.ack;
  assign wr_go = wb_i.cyc & wb_i.stb & wb_i.we & q.ack;
  assign wmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
  always_comb begin
    if (wb_i.adr == OFS_CTRL) begin
      rd_mux = {20'h00000, q.ctrl};
    end else if (wb_i.adr == OFS_STAT) begin
      rd_mux = {26'h0000000, q.buf_rdy, q.buf_rdy, q.buf_rdy, q.scaler_rdy,
                q.ch[1].ph != TID_CH_IDLE, q.ch[0].ph != TID_CH_IDLE};
    end else if (wb_i.adr == OFS_BUFLO) begin
      rd_mux = q.bufr[31:0];
    end else if (wb_i.adr == OFS_BUFHI) begin
      rd_mux = {29'h00000000, q.bufr[RES_W-1:32]};
    end else if (wb_i.adr == OFS_SCLO) begin
      rd_mux = q.scaler[31:0];
    end else if (wb_i.adr == OFS_SCHI) begin
      rd_mux = {29'h00000000, q.scaler[RES_W-1:32]};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // Clears from the dataway and from the front panel buttons
  assign clr_buf = (wr_go & (wb_i.adr == OFS_CMD) & wb_i.sel[0] & wb_i.dat[0])
                 | (q.s2.man_clr_buf & ~q.s3.man_clr_buf);
  assign clr_sc = (wr_go & (wb_i.adr == OFS_CMD) & wb_i.sel[0] & wb_i.dat[1])
                | (q.s2.man_clr_sc & ~q.s3.man_clr_sc);
  assign done_xfer = (q.st == TID_S_XFER) & ~q.buf_rdy;
  // Range overflow on an open coarse count discards the event
  assign ovr_hit = (q.st == TID_S_RUN) & q.main_open & (q.main_cnt >= rng_lim);

  // Next state
  always_comb begin
    d = q;
    d.s1 = pins_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.div = (q.div == DIV_LAST) ? 3'h0 : q.div + 3'h1;
    d.clk_out = q.ctrl[CB_EXT] ? q.s2.ext_clk : (q.div < DIV_HALF);
    d.addressed = 1'b0;
    d.overrun = 1'b0;
    // Wishbone slave: ack one cycle after request, dropped after
    d.ack = bus_go;
    if (bus_go) begin
      d.rdat = rd_mux;
      d.addressed = (wb_i.adr == OFS_BUFLO) | (wb_i.adr == OFS_BUFHI);
    end
    if (wr_go && wb_i.adr == OFS_CTRL) begin
      d.ctrl = (q.ctrl & ~wmask[11:0]) | (wb_i.dat[11:0] & wmask[11:0]);
    end
    // Interpolator channels: fine count, stretched gate, tick scaler
    for (int i = 0; i < 2; i++) begin
      case (q.ch[i].ph)
        TID_CH_IDLE: begin
          if (acc[i]) begin
            d.ch[i].ph = TID_CH_FINE;
            d.ch[i].cnt = 14'h0001;
            d.ch[i].scal = '0;
          end
        end
        TID_CH_FINE: begin
          if (tick) begin
            d.ch[i].ph = TID_CH_GATE;
            d.ch[i].cnt = q.ch[i].cnt << STRETCH_SH;
          end else begin
            d.ch[i].cnt = q.ch[i].cnt + 14'h0001;
          end
        end
        TID_CH_GATE: begin
          d.ch[i].cnt = q.ch[i].cnt - 14'h0001;
          if (tick) begin
            d.ch[i].scal = q.ch[i].scal + FINE_W'(1);
          end
          if (q.ch[i].cnt == 14'h0001) begin
            d.ch[i].ph = TID_CH_DONE;
          end
        end
        default: begin
        end
      endcase
    end
    // Main scaler opens with start gate, closes at stop gate edge
    if (q.ch[0].ph == TID_CH_FINE && tick) begin
      d.main_open = 1'b1;
      d.main_cnt = '0;
    end else if (q.ch[1].ph == TID_CH_FINE && tick) begin
      d.main_open = 1'b0;
      // The stop tick closes the last whole period of the coarse count
      if (q.main_open) begin
        d.main_cnt = q.main_cnt + (MAIN_W+1)'(1);
      end
    end else if (q.main_open && tick) begin
      d.main_cnt = q.main_cnt + (MAIN_W+1)'(1);
    end
    // Sequencer
    case (q.st)
      TID_S_IDLE: begin
        if (acc[0]) begin
          d.st = TID_S_RUN;
        end
      end
      TID_S_RUN: begin
        if (q.main_open && q.main_cnt >= rng_lim) begin
          d.overrun = 1'b1;
          d.st = TID_S_IDLE;
          d.ch = '0;
          d.main_open = 1'b0;
        end else if (q.ch[0].ph == TID_CH_DONE && q.ch[1].ph == TID_CH_DONE) begin
          d.scaler = result;
          d.st = TID_S_XFER;
        end
      end
      TID_S_XFER: begin
        if (done_xfer) begin
          d.bufr = q.scaler;
          d.st = TID_S_IDLE;
          d.ch = '0;
          d.main_open = 1'b0;
          d.main_cnt = '0;
        end
      end
      default: begin
        d.st = TID_S_IDLE;
      end
    endcase
    // Ready flags: a load beats a clear in the same cycle
    if (clr_sc) begin
      d.scaler_rdy = 1'b0;
    end
    if (q.st == TID_S_RUN && d.st == TID_S_XFER) begin
      d.scaler_rdy = 1'b1;
    end
    if (clr_buf) begin
      d.buf_rdy = 1'b0;
    end
    if (done_xfer) begin
      d.buf_rdy = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign wb_o.ack = q.ack;
  assign wb_o.dat = q.rdat;
  assign start_busy_o = q.ch[0].ph != TID_CH_IDLE;
  assign stop_busy_o = q.ch[1].ph != TID_CH_IDLE;
  assign scaler_rdy_o = q.scaler_rdy;
  assign buf_rdy_o = q.buf_rdy;
  assign lam_o = q.buf_rdy;
  assign addressed_o = q.addressed;
  assign overrun_o = q.overrun;
  assign clk_out_o = q.clk_out;
  assign disp_valid_o = q.scaler_rdy;
  assign disp_o = q.scaler;
  assign buf_o = q.bufr;

  // Checks
  property p_busy_ign;
    @(posedge clk_i) disable iff (rst_i)
    (q.ch[0].ph != TID_CH_IDLE) |=> (q.ch[0].ph != TID_CH_FINE) || $past(q.ch[0].ph) == TID_CH_FINE;
  endproperty
  a_busy_ign: assert property (p_busy_ign) else $error("busy start re-accepted");
  property p_gate_q;
    @(posedge clk_i) disable iff (rst_i)
    acc[0] |-> (q.s2.start_gate != q.ctrl[CB_ST_ANTI]);
  endproperty
  a_gate_q: assert property (p_gate_q) else $error("start taken against gate");
  property p_arm;
    @(posedge clk_i) disable iff (rst_i)
    acc[1] && arm_sel != 4'h0 |-> q.st == TID_S_RUN && q.main_cnt >= arm_lim;
  endproperty
  a_arm: assert property (p_arm) else $error("stop taken while disarmed");
  property p_stretch;
    @(posedge clk_i) disable iff (rst_i)
    q.ch[1].ph == TID_CH_FINE && tick |=> q.ch[1].cnt[STRETCH_SH-1:0] == '0 && !q.main_open;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stop gate bad");
  property p_xfer;
    @(posedge clk_i) disable iff (rst_i)
    done_xfer |=> q.st == TID_S_IDLE && !start_busy_o && !stop_busy_o && q.buf_rdy
      && q.bufr == $past(q.scaler);
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer or clear wrong");
  property p_rdy_hold;
    @(posedge clk_i) disable iff (rst_i)
    q.scaler_rdy && !clr_sc |=> q.scaler_rdy;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("scaler ready dropped");
  property p_ovr;
    @(posedge clk_i) disable iff (rst_i)
    overrun_o |-> !$past(overrun_o) && q.st == TID_S_IDLE && !start_busy_o;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not single pulse");
  property p_bufclr;
    @(posedge clk_i) disable iff (rst_i)
    clr_buf && !done_xfer |=> !q.buf_rdy && !lam_o;
  endproperty
  a_bufclr: assert property (p_bufclr) else $error("buffer reset lost");
  property p_start_len;
    @(posedge clk_i) disable iff (rst_i)
    q.ch[0].ph == TID_CH_FINE && tick && !ovr_hit
      |=> q.ch[0].ph == TID_CH_GATE && q.ch[0].cnt == ($past(q.ch[0].cnt) << STRETCH_SH);
  endproperty
  a_start_len: assert property (p_start_len) else $error("start gate length wrong");
  property p_stop_len;
    @(posedge clk_i) disable iff (rst_i)
    q.ch[1].ph == TID_CH_FINE && tick && !ovr_hit
      |=> q.ch[1].ph == TID_CH_GATE && q.ch[1].cnt == ($past(q.ch[1].cnt) << STRETCH_SH);
  endproperty
  a_stop_len: assert property (p_stop_len) else $error("stop gate length wrong");
  property p_scal_cnt;
    @(posedge clk_i) disable iff (rst_i)
    q.ch[0].ph == TID_CH_GATE && tick && !ovr_hit
      |=> q.ch[0].scal == $past(q.ch[0].scal) + FINE_W'(1);
  endproperty
  a_scal_cnt: assert property (p_scal_cnt) else $error("start scaler missed a tick");
  property p_start_hold;
    @(posedge clk_i) disable iff (rst_i)
    start_busy_o && !done_xfer && !ovr_hit |=> start_busy_o;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("start busy fell early");
  property p_stop_hold;
    @(posedge clk_i) disable iff (rst_i)
    stop_busy_o && !done_xfer && !ovr_hit |=> stop_busy_o;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop busy fell early");
  property p_free_arm;
    @(posedge clk_i) disable iff (rst_i)
    arm_sel == 4'h0 && edge_in[1] && gate_ok[1] && !stop_busy_o && !ovr_hit |=> stop_busy_o;
  endproperty
  a_free_arm: assert property (p_free_arm) else $error("free armed stop refused");
  property p_ovr_clr;
    @(posedge clk_i) disable iff (rst_i)
    ovr_hit |=> overrun_o && !start_busy_o && !stop_busy_o && !q.main_open;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun did not discard");
  property p_addr;
    @(posedge clk_i) disable iff (rst_i)
    bus_go && wb_i.adr == OFS_BUFLO |=> addressed_o;
  endproperty
  a_addr: assert property (p_addr) else $error("buffer access not flagged");
  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    wb_o.ack |=> !wb_o.ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_man_sc;
    @(posedge clk_i) disable iff (rst_i)
    q.s2.man_clr_sc && !q.s3.man_clr_sc && !(q.st == TID_S_RUN && d.st == TID_S_XFER)
      |=> !scaler_rdy_o;
  endproperty
  a_man_sc: assert property (p_man_sc) else $error("scaler button ignored");
  property p_man_buf;
    @(posedge clk_i) disable iff (rst_i)
    q.s2.man_clr_buf && !q.s3.man_clr_buf && !done_xfer |=> !buf_rdy_o;
  endproperty
  a_man_buf: assert property (p_man_buf) else $error("buffer button ignored");
  property p_disp;
    @(posedge clk_i) disable iff (rst_i)
    disp_valid_o && !clr_sc && q.st != TID_S_RUN |=> disp_valid_o && $stable(disp_o);
  endproperty
  a_disp: assert property (p_disp) else $error("display changed while valid");
  property p_ext_out;
    @(posedge clk_i) disable iff (rst_i)
    q.ctrl[CB_EXT] |=> clk_out_o == $past(q.s2.ext_clk);
  endproperty
  a_ext_out: assert property (p_ext_out) else $error("external clock not passed out");
  property p_xfer_wait;
    @(posedge clk_i) disable iff (rst_i)
    q.st == TID_S_XFER && q.buf_rdy && !clr_buf
      |=> q.st == TID_S_XFER && start_busy_o && stop_busy_o;
  endproperty
  a_xfer_wait: assert property (p_xfer_wait) else $error("held event lost");
  // Refused stop while start converts, and a freely armed stop
  c_stop_refused: cover property (@(posedge clk_i) edge_in[1] && !acc[1] && start_busy_o);
  c_free_arm: cover property (@(posedge clk_i) acc[1] && arm_sel == 4'h0);
  c_event: cover property (@(posedge clk_i) done_xfer);
  c_over: cover property (@(posedge clk_i) overrun_o);
  c_wait: cover property (@(posedge clk_i) q.st == TID_S_XFER && q.buf_rdy);
endmodule : tid_top

// ==== tid_host.sv ====
`timescale 1ns/1ps
module tid_host (
  // Bus side
  input wire logic clk_i,
  input wire tid_pkg::tid_wb_rsp_t wb_i,
  output tid_pkg::tid_wb_req_t wb_o
);
  import tid_pkg::*;
  // Idle bus at time zero
  initial wb_o = '0;
  // One classic cycle, held until ack; released lines show inverted values
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do @(posedge clk_i); while (wb_i.ack !== 1'b1);
    wb_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, sel: 4'h0, adr: ~a, dat: ~d};
    @(posedge clk_i);
  endtask : xfer
endmodule : tid_host

// ==== time_interval_digitizer_control_tb.sv ====
`timescale 1ns/1ps
module time_interval_digitizer_control_tb;
  import tid_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tid_wb_req_t wb_req;
  tid_wb_rsp_t wb_rsp;
  tid_pins_t pins = '0;
  logic start_busy, stop_busy, scaler_rdy, buf_rdy, lam, addressed, overrun, clk_out, disp_valid;
  logic [RES_W-1:0] disp, buf_val;
  logic [31:0] notes[$];
  logic [31:0] lfsr = 32'h34824c67;
  int err_total = 0, n_checks = 0, n_addr = 0, n_addr_exp = 0, n_ovr = 0;

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  tid_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_req), .wb_o(wb_rsp), .pins_i(pins),
    .start_busy_o(start_busy), .stop_busy_o(stop_busy), .scaler_rdy_o(scaler_rdy),
    .buf_rdy_o(buf_rdy), .lam_o(lam), .addressed_o(addressed), .overrun_o(overrun),
    .clk_out_o(clk_out), .disp_valid_o(disp_valid), .disp_o(disp), .buf_o(buf_val));
  tid_host u_host (.clk_i(clk_i), .wb_i(wb_rsp), .wb_o(wb_req));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Interval of d cycles expressed in result units
  function automatic logic [RES_W-1:0] lsb_of(input int d);
    return RES_W'(d / DIV_N) << STRETCH_SH;
  endfunction : lsb_of
  function automatic logic flag(input int w);
    case (w)
      0: return buf_rdy;
      1: return scaler_rdy;
      default: return ~start_busy;
    endcase
  endfunction : flag

  // Comparisons
  task automatic chk_dat(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_dat
  task automatic chk_bit(input logic got, input logic exp);
    chk_dat(RES_W'(got), RES_W'(exp));
  endtask : chk_bit

  // Read answers are matched against the oldest note
  always @(posedge clk_i) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0 && notes.size() > 0) begin
      chk_dat(RES_W'(wb_rsp.dat), RES_W'(notes.pop_front()));
    end
    if (addressed === 1'b1) n_addr++;
    if (overrun === 1'b1) n_ovr++;
  end

  // Bus access helpers
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    notes.push_back(e);
    if (a == OFS_BUFLO || a == OFS_BUFHI) n_addr_exp++;
    u_host.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask : wr

  // Pulse the chosen inputs; the next pulse comes n cycles later
  task automatic go(input logic st, input logic sp, input int n);
    @(posedge clk_i);
    pins.start <= st;
    pins.stop <= sp;
    repeat (2) @(posedge clk_i);
    pins.start <= 1'b0;
    pins.stop <= 1'b0;
    repeat (n - 3) @(posedge clk_i);
  endtask : go
  task automatic mclr(input logic sc, input logic bf);
    pins.man_clr_sc <= sc;
    pins.man_clr_buf <= bf;
    repeat (2) @(posedge clk_i);
    pins.man_clr_sc <= 1'b0;
    pins.man_clr_buf <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : mclr
  task automatic wait_for(input int w);
    int k;
    k = 0;
    while (flag(w) !== 1'b1 && k < 30000) begin
      @(posedge clk_i);
      k++;
    end
    chk_bit(flag(w), 1'b1);
  endtask : wait_for
  task automatic pick(output int d);
    lfsr = lfsr_next(lfsr);
    d = DIV_N * (12 + int'(lfsr[4:0]));
  endtask : pick
  // Start, then stop d cycles later; sources never send stop first
  task automatic meas(input int d);
    go(1'b1, 1'b0, d);
    go(1'b0, 1'b1, 3);
  endtask : meas
  // Read both buffer halves, then reset the buffer over the bus
  task automatic take(input int d);
    logic [RES_W-1:0] e;
    e = lsb_of(d);
    wait_for(0);
    chk_bit(lam, 1'b1);
    rd(OFS_BUFLO, e[31:0]);
    rd(OFS_BUFHI, {29'h0, e[34:32]});
    wr(OFS_CMD, 32'h1);
  endtask : take

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // Watchdog
  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    close_out();
  end

  // Main sequence
  initial begin
    int d, d2, o;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CTRL, {20'h0, CTRL_RST});
    rd(8'hfc, 32'h0);
    wr(OFS_CTRL, 32'h916);
    rd(OFS_CTRL, 32'h916);
    pick(d);
    go(1'b1, 1'b1, d);
    chk_bit(start_busy, 1'b1);
    chk_bit(stop_busy, 1'b0);
    go(1'b1, 1'b1, 3);
    repeat (6) @(posedge clk_i);
    chk_bit(stop_busy, 1'b1);
    take(d);
    chk_bit(start_busy | stop_busy | buf_rdy, 1'b0);
    $display("test paired pulses done");
    wr(OFS_CTRL, 32'h906);
    pick(d);
    meas(d);
    wait_for(0);
    mclr(1'b1, 1'b0);
    chk_bit(scaler_rdy | disp_valid, 1'b0);
    pick(d2);
    meas(d2);
    wait_for(1);
    chk_dat(disp, lsb_of(d2));
    chk_bit(disp_valid & start_busy, 1'b1);
    chk_dat(buf_val, lsb_of(d));
    rd(OFS_BUFLO, 32'(lsb_of(d)));
    mclr(1'b0, 1'b1);
    take(d2);
    mclr(1'b1, 1'b0);
    chk_bit(scaler_rdy | buf_rdy, 1'b0);
    $display("test buffer full done");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, 32'h900 | (i[0] ? 32'h6 : 32'h0));
      pins.start_gate <= i[1];
      pins.stop_gate <= i[1];
      pick(d);
      meas(d);
      repeat (4) @(posedge clk_i);
      chk_bit(start_busy, i[0] ^ i[1]);
      chk_bit(stop_busy, i[0] ^ i[1]);
      if (i[0] ^ i[1]) take(d);
    end
    pins.start_gate <= 1'b0;
    pins.stop_gate <= 1'b0;
    $display("test gate modes done");
    wr(OFS_CTRL, 32'h926);
    pick(d);
    go(1'b1, 1'b0, 4);
    go(1'b0, 1'b1, d - 4);
    chk_bit(stop_busy, 1'b0);
    go(1'b0, 1'b1, 3);
    take(d);
    $display("test stop arming done");
    wr(OFS_CTRL, 32'h006);
    o = n_ovr;
    go(1'b1, 1'b0, 3);
    repeat (4) @(posedge clk_i);
    chk_bit(start_busy, 1'b1);
    wait_for(2);
    repeat (2) @(posedge clk_i);
    chk_bit(n_ovr == o + 1, 1'b1);
    chk_bit(buf_rdy, 1'b0);
    $display("test overrun done");
    wr(OFS_CTRL, 32'h907);
    repeat (12) @(posedge clk_i);
    chk_bit(clk_out, 1'b0);
    pins.ext_clk <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk_bit(clk_out, 1'b1);
    chk_bit(n_addr == n_addr_exp, 1'b1);
    $display("test clock select done");
    close_out();
  end
endmodule : time_interval_digitizer_control_tb
